/* rtl/csa_pkg.sv */
// shared constants and types of the cpu sequencer core
package csa_pkg;
  // ----------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------
  localparam logic [7:0] REG_PCL_ADDR   = 8'h00;
  localparam logic [7:0] REG_CTRL_ADDR  = 8'h04;
  localparam logic [7:0] REG_STAT_ADDR  = 8'h08;
  localparam logic       CTRL_OSC_RESET = 1'h0;
  localparam int         CTRL_OSC_BIT   = 0;
  localparam int         STAT_CARRY_BIT = 8;
  localparam int         STAT_ZERO_BIT  = 9;
  localparam int         STAT_FULL_BIT  = 10;
  localparam int         STAT_LEVEL_LSB = 12;
  localparam int         STAT_PCH_LSB   = 16;
  // ----------------------------------------------------------
  // sizes, reset values and timing
  // ----------------------------------------------------------
  localparam int              PC_W         = 11;
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
  localparam int              STACK_DEPTH  = 8;
  localparam int              SP_W         = 4;
  localparam int              DMEM_DEPTH   = 16;
  localparam int              DMEM_AW      = 4;
  localparam int              FAST_OSC_KHZ = 100000;
  localparam int              SLOW_OSC_KHZ = 32;
  localparam int              SLOW_DIV     = FAST_OSC_KHZ / SLOW_OSC_KHZ;
  localparam int              DIV_W        = 12;
  // ----------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------
  localparam int IR_CLS_LSB   = 12;
  localparam int IR_OP_LSB    = 8;
  localparam int IR_SEL_BIT   = 8;
  // ----------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } csa_phase_e;
  typedef enum logic [3:0] {
    CLS_ALU_ACC = 4'h0, CLS_ALU_MEM = 4'h1, CLS_LOAD = 4'h2,
    CLS_STORE   = 4'h3, CLS_JUMP    = 4'h4, CLS_CALL = 4'h5,
    CLS_RET     = 4'h6, CLS_INTERRUPT_EXIT_OP    = 4'h7, CLS_SZ   = 4'h8,
    CLS_SNZ     = 4'h9, CLS_SIZ     = 4'ha, CLS_SDZ  = 4'hb,
    CLS_NOP     = 4'hf
  } csa_cls_e;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR  = 4'h5, ALU_XOR = 4'h6, ALU_CPL = 4'h7,
    ALU_RR  = 4'h8, ALU_RRC = 4'h9, ALU_RL  = 4'ha, ALU_RLC = 4'hb,
    ALU_INC = 4'hc, ALU_DEC = 4'hd, ALU_DAA = 4'he, ALU_PASS = 4'hf
  } csa_alu_e;
endpackage

/* rtl/csa_alu.sv */
// 8-bit arithmetic and logic datapath
`timescale 1ns/1ns
module csa_alu
  import csa_pkg::*;
(
  input  wire csa_alu_e   op_in,     // operation
  input  wire logic [7:0] a_in,      // first operand
  input  wire logic [7:0] b_in,      // second operand
  input  wire logic       carry_in,  // carry flag
  output logic      [7:0] res_out,   // result
  output logic            carry_out, // new carry, no borrow on sub
  output logic            zero_out   // result is zero
);
  logic [8:0] sum9;
  logic [8:0] daa9;

  always_comb begin
    sum9      = 9'h000;
    daa9      = 9'h000;
    res_out   = a_in;
    carry_out = carry_in;
    case (op_in)
      ALU_ADD, ALU_ADC: begin
        sum9 = {1'b0, a_in} + {1'b0, b_in} +
               {8'h00, carry_in & (op_in == ALU_ADC)};
        res_out   = sum9[7:0];
        carry_out = sum9[8];
      end
      ALU_SUB: begin
        sum9 = {1'b0, a_in} + {1'b0, ~b_in} + 9'h001;
        res_out   = sum9[7:0];
        carry_out = sum9[8];
      end
      ALU_SBC: begin
        sum9 = {1'b0, a_in} + {1'b0, ~b_in} + {8'h00, carry_in};
        res_out   = sum9[7:0];
        carry_out = sum9[8];
      end
      ALU_AND: res_out = a_in & b_in;
      ALU_OR:  res_out = a_in | b_in;
      ALU_XOR: res_out = a_in ^ b_in;
      ALU_CPL: res_out = ~a_in;
      ALU_RR:  res_out = {a_in[0], a_in[7:1]};
      ALU_RL:  res_out = {a_in[6:0], a_in[7]};
      ALU_RRC: begin
        res_out   = {carry_in, a_in[7:1]};
        carry_out = a_in[0];
      end
      ALU_RLC: begin
        res_out   = {a_in[6:0], carry_in};
        carry_out = a_in[7];
      end
      ALU_INC: res_out = a_in + 8'h01;
      ALU_DEC: res_out = a_in - 8'h01;
      ALU_DAA: begin
        // low nibble then high nibble correction
        daa9 = {1'b0, a_in} + ((a_in[3:0] > 4'h9) ? 9'h006 : 9'h000);
        if ((daa9[7:4] > 4'h9) || daa9[8] || carry_in) begin
          daa9      = daa9 + 9'h060;
          carry_out = 1'b1;
        end
        res_out = daa9[7:0];
      end
      ALU_PASS: res_out = b_in;
      default:  res_out = a_in;
    endcase
  end

  assign zero_out = (res_out == 8'h00);
endmodule // csa_alu

/* rtl/csa_core.sv */
// instruction sequencer, return stack and alu control of the cpu core
`timescale 1ns/1ns
module csa_core
  import csa_pkg::*;
(
  input  wire logic            clk_in,         // 100 MHz system clock
  input  wire logic            reset_n_in,     // async reset, active low
  input  wire logic            psel_in,        // apb select
  input  wire logic            penable_in,     // apb enable
  input  wire logic            pwrite_in,      // apb write
  input  wire logic [7:0]      paddr_in,       // apb byte address
  input  wire logic [31:0]     pwdata_in,      // apb write data
  output logic      [31:0]     prdata_out,     // apb read data
  output logic                 pready_out,     // apb ready
  output logic                 pslverr_out,    // apb error
  output logic      [PC_W-1:0] prog_addr_out,  // program memory address
  input  wire logic [15:0]     prog_data_in,   // program memory word
  input  wire logic            int_req_in,     // pending enabled interrupt
  input  wire logic [PC_W-1:0] int_vector_in,  // interrupt entry address
  output logic                 int_ack_out,    // interrupt acknowledge
  output logic      [3:0]      instruction_phase_clocks_out, // INSTRUCTION_PHASE_CLOCKS
  output logic                 stack_full_out  // return stack full
);
  // ----------------------------------------------------------
  // phase generator
  // ----------------------------------------------------------
  csa_phase_e        phase_reg;
  csa_phase_e        phase_next;
  logic [DIV_W-1:0]  div_reg;
  logic              osc_slow_reg;
  logic              slow_tick;
  logic              tick;
  logic              t1_tick;
  logic              t4_tick;

  assign slow_tick = (div_reg == DIV_W'(SLOW_DIV - 1));
  assign tick      = osc_slow_reg ? slow_tick : 1'b1;
  assign t1_tick   = tick & (phase_reg == PH_T1);
  assign t4_tick   = tick & (phase_reg == PH_T4);

  always_comb begin
    case (phase_reg)
      PH_T1:   phase_next = PH_T2;
      PH_T2:   phase_next = PH_T3;
      PH_T3:   phase_next = PH_T4;
      PH_T4:   phase_next = PH_T1;
      default: phase_next = PH_T1;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_reg   <= '0;
      phase_reg <= PH_T1;
    end else begin
      div_reg <= slow_tick ? '0 : div_reg + DIV_W'(1);
      if (tick) begin
        phase_reg <= phase_next;
      end
    end
  end

  assign instruction_phase_clocks_out = phase_reg;

  // ----------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------
  logic [PC_W-1:0]    pc_reg;
  logic [15:0]        ir_reg;
  logic               ir_valid_reg;
  logic [15:0]        fetch_reg;
  logic               fetch_valid_reg;
  logic [7:0]         acc_reg;
  logic               carry_reg;
  logic               zero_reg;
  logic [7:0]         dmem [DMEM_DEPTH];
  csa_cls_e           cls;
  csa_alu_e           ir_op;
  csa_alu_e           alu_op;
  logic [DMEM_AW-1:0] midx;
  logic [7:0]         mem_val;
  logic               sel_bit;
  logic               skip_cls;
  logic [7:0]         skip_src;
  logic               unary_mem;
  logic [7:0]         alu_a;
  logic [7:0]         alu_res;
  logic               alu_carry;
  logic               alu_zero;
  logic               exec;
  logic               alu_cls;

  assign cls      = csa_cls_e'(ir_reg[IR_CLS_LSB +: 4]);
  assign ir_op    = csa_alu_e'(ir_reg[IR_OP_LSB +: 4]);
  assign midx     = ir_reg[DMEM_AW-1:0];
  assign mem_val  = dmem[midx];
  assign sel_bit  = ir_reg[IR_SEL_BIT];
  assign skip_cls = (cls == CLS_SIZ) | (cls == CLS_SDZ);
  assign skip_src = sel_bit ? acc_reg : mem_val;
  assign alu_cls  = (cls == CLS_ALU_ACC) | (cls == CLS_ALU_MEM);
  assign exec     = t4_tick & ir_valid_reg;
  // single-operand ops other than daa act on the memory byte
  assign unary_mem = (ir_op >= ALU_CPL) & (ir_op != ALU_DAA) &
                     (ir_op != ALU_PASS);
  assign alu_a  = skip_cls ? skip_src : (unary_mem ? mem_val : acc_reg);
  assign alu_op = (cls == CLS_SIZ) ? ALU_INC :
                  (cls == CLS_SDZ) ? ALU_DEC : ir_op;

  csa_alu i_csa_alu (
    .op_in     (alu_op),
    .a_in      (alu_a),
    .b_in      (mem_val),
    .carry_in  (carry_reg),
    .res_out   (alu_res),
    .carry_out (alu_carry),
    .zero_out  (alu_zero)
  );

  // ----------------------------------------------------------
  // branch and skip control
  // ----------------------------------------------------------
  logic            skip_hit;
  logic            instr_jump;
  logic            pcl_pend_reg;
  logic [7:0]      pcl_data_reg;
  logic            pcl_apply;
  logic            irq_take;
  logic            flush;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] stack_top;
  logic [PC_W-1:0] jump_target;
  logic [SP_W-1:0] level_reg;
  logic            stack_full;

  assign skip_hit = exec & (((cls == CLS_SZ) & (skip_src == 8'h00)) |
                            ((cls == CLS_SNZ) & (skip_src != 8'h00)) |
                            (skip_cls & alu_zero));
  assign instr_jump = exec & ((cls == CLS_JUMP) | (cls == CLS_CALL) |
                              (cls == CLS_RET) | (cls == CLS_INTERRUPT_EXIT_OP) |
                              ((cls == CLS_STORE) & sel_bit));
  assign pcl_apply  = t4_tick & pcl_pend_reg & ~instr_jump;
  assign irq_take   = t4_tick & int_req_in & ~stack_full &
                      ir_valid_reg & fetch_valid_reg & ~instr_jump &
                      ~skip_hit & ~pcl_pend_reg;
  assign flush = instr_jump | skip_hit | pcl_apply | irq_take;
  assign push  = (exec & (cls == CLS_CALL)) | irq_take;
  assign pop   = exec & ((cls == CLS_RET) | (cls == CLS_INTERRUPT_EXIT_OP));
  // prefetched word sits at pc-1, so that is where to come back
  assign ret_addr = pc_reg - PC_W'(1);
  assign jump_target =
    ((cls == CLS_RET) | (cls == CLS_INTERRUPT_EXIT_OP)) ? stack_top :
    (cls == CLS_STORE) ? {pc_reg[PC_W-1:8], acc_reg} :
    ir_reg[PC_W-1:0];
  assign int_ack_out = irq_take;

  // ----------------------------------------------------------
  // program counter and fetch pipeline
  // ----------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_reg <= RESET_VECTOR;
    end else if (instr_jump) begin
      pc_reg <= jump_target;
    end else if (pcl_apply) begin
      pc_reg <= {pc_reg[PC_W-1:8], pcl_data_reg};
    end else if (irq_take) begin
      pc_reg <= int_vector_in;
    end else if (t1_tick) begin
      pc_reg <= pc_reg + PC_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_reg          <= 16'hf000;
      ir_valid_reg    <= 1'b0;
      fetch_reg       <= 16'hf000;
      fetch_valid_reg <= 1'b0;
    end else if (t1_tick) begin
      ir_reg          <= fetch_reg;
      ir_valid_reg    <= fetch_valid_reg;
      fetch_reg       <= prog_data_in;
      fetch_valid_reg <= 1'b1;
    end else if (flush) begin
      fetch_valid_reg <= 1'b0;
    end
  end

  assign prog_addr_out = pc_reg;

  // ----------------------------------------------------------
  // return stack, shifted so overflow drops the oldest
  // ----------------------------------------------------------
  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      logic [PC_W-1:0] entry_reg;
      logic [PC_W-1:0] from_above;
      logic [PC_W-1:0] from_below;
      if (i == 0) begin : g_first
        assign from_above = ret_addr;
      end else begin : g_rest
        assign from_above = g_stack[i-1].entry_reg;
      end
      if (i == STACK_DEPTH - 1) begin : g_last
        assign from_below = '0;
      end else begin : g_inner
        assign from_below = g_stack[i+1].entry_reg;
      end
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          entry_reg <= '0;
        end else if (push) begin
          entry_reg <= from_above;
        end else if (pop) begin
          entry_reg <= from_below;
        end
      end
    end
  endgenerate

  assign stack_top      = g_stack[0].entry_reg;
  assign stack_full     = (level_reg == SP_W'(STACK_DEPTH));
  assign stack_full_out = stack_full;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_reg <= '0;
    end else if (push & ~stack_full) begin
      level_reg <= level_reg + SP_W'(1);
    end else if (pop & ~push & (level_reg != '0)) begin
      level_reg <= level_reg - SP_W'(1);
    end
  end

  // ----------------------------------------------------------
  // accumulator, flags and data bytes
  // ----------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_reg   <= 8'h00;
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (exec) begin
      if ((cls == CLS_ALU_ACC) | (skip_cls & sel_bit)) begin
        acc_reg <= alu_res;
      end else if (cls == CLS_LOAD) begin
        acc_reg <= ir_reg[7:0];
      end
      if (alu_cls) begin
        carry_reg <= alu_carry;
        zero_reg  <= alu_zero;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (exec) begin
      if ((cls == CLS_ALU_MEM) | (skip_cls & ~sel_bit)) begin
        dmem[midx] <= alu_res;
      end else if ((cls == CLS_STORE) & ~sel_bit) begin
        dmem[midx] <= acc_reg;
      end
    end
  end

  // ----------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------
  logic        apb_setup;
  logic        apb_access;
  logic        hit_pcl;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        addr_hit;
  logic        pcl_wr;
  logic [31:0] rd_word;
  logic [31:0] prdata_reg;

  assign apb_setup  = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in;
  assign hit_pcl    = (paddr_in == REG_PCL_ADDR);
  assign hit_ctrl   = (paddr_in == REG_CTRL_ADDR);
  assign hit_stat   = (paddr_in == REG_STAT_ADDR);
  assign addr_hit   = hit_pcl | hit_ctrl | hit_stat;
  assign pcl_wr     = apb_access & pwrite_in & hit_pcl;
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access & ~addr_hit;
  // stack contents and pointer are deliberately not mapped
  assign rd_word =
    hit_pcl  ? {24'h000000, pc_reg[7:0]} :
    hit_ctrl ? {31'h00000000, osc_slow_reg} :
    hit_stat ? {13'h0000, pc_reg[PC_W-1:8], 4'h0, 1'b0,
                stack_full, zero_reg, carry_reg, acc_reg} :
    32'h00000000;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_reg   <= 32'h00000000;
      osc_slow_reg <= CTRL_OSC_RESET;
      pcl_pend_reg <= 1'b0;
      pcl_data_reg <= 8'h00;
    end else begin
      if (apb_setup) begin
        prdata_reg <= rd_word;
      end
      if (apb_access & pwrite_in & hit_ctrl) begin
        osc_slow_reg <= pwdata_in[CTRL_OSC_BIT];
      end
      if (pcl_wr) begin
        pcl_data_reg <= pwdata_in[7:0];
      end
      pcl_pend_reg <= pcl_wr | (pcl_pend_reg & ~pcl_apply);
    end
  end

  assign prdata_out = prdata_reg;
endmodule // csa_core

/* verification/csa_core_properties.sv */
// concurrent checks on the ports of the cpu sequencer core
`timescale 1ns/1ns
module csa_core_properties
  import csa_pkg::*;
(
  input wire logic            clk_in,         // clock
  input wire logic            reset_n_in,     // reset, active low
  input wire logic            psel_in,        // apb select
  input wire logic            penable_in,     // apb enable
  input wire logic            pwrite_in,      // apb write
  input wire logic [7:0]      paddr_in,       // apb address
  input wire logic [31:0]     pwdata_in,      // apb write data
  input wire logic [31:0]     prdata_out,     // apb read data
  input wire logic            pready_out,     // apb ready
  input wire logic            pslverr_out,    // apb error
  input wire logic [PC_W-1:0] prog_addr_out,  // fetch address
  input wire logic [15:0]     prog_data_in,   // fetched word
  input wire logic            int_req_in,     // interrupt request
  input wire logic [PC_W-1:0] int_vector_in,  // interrupt entry
  input wire logic            int_ack_out,    // acknowledge
  input wire logic [3:0]      instruction_phase_clocks_out, // phase
  input wire logic            stack_full_out  // stack full
);
  // ----------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [3:0] ph;
  logic [3:0] ph_rot;
  logic       acc_rd;
  logic       mapped;
  logic [7:0] pc_low_byte;
  logic [2:0] pch;
  assign ph     = instruction_phase_clocks_out;
  assign ph_rot = {ph[2:0], ph[3]};
  assign acc_rd = psel_in && penable_in && !pwrite_in;
  assign mapped = paddr_in inside {REG_PCL_ADDR, REG_CTRL_ADDR, REG_STAT_ADDR};
  assign pc_low_byte    = prog_addr_out[7:0];
  assign pch    = prog_addr_out[10:8];

  AST_PHASE_ONEHOT: assert property ($onehot(ph))
    else $error("phase is not one-hot");
  AST_PHASE_STEP: assert property (
    $changed(ph) |-> ph == $past(ph_rot))
    else $error("phase skipped a step");
  AST_PC_WHEN: assert property (
    $changed(prog_addr_out) |-> $past(ph) inside {PH_T1, PH_T4})
    else $error("pc moved outside first or last phase");
  AST_PC_INC: assert property (
    $past(ph) == PH_T1 && ph == PH_T2 |->
      prog_addr_out == $past(prog_addr_out) + 11'h1)
    else $error("pc did not advance by one at fetch");
  AST_ACK_WHEN: assert property (
    int_ack_out |-> ph == PH_T4 && int_req_in && !stack_full_out)
    else $error("acknowledge without cause or while full");
  AST_ACK_LOAD: assert property (
    int_ack_out |=> prog_addr_out == $past(int_vector_in))
    else $error("vector not loaded after acknowledge");
  AST_ACK_PULSE: assert property (int_ack_out |=> !int_ack_out [*3])
    else $error("acknowledge longer than one pulse");
  AST_READY: assert property (psel_in |-> pready_out)
    else $error("register access waited");
  AST_SLVERR: assert property (
    psel_in && penable_in |-> pslverr_out == !mapped)
    else $error("error response wrong for address");
  AST_PCL_READ: assert property (
    acc_rd && paddr_in == REG_PCL_ADDR |-> prdata_out == {24'h0, $past(pc_low_byte)})
    else $error("pc low byte read wrong");
  AST_STAT_READ: assert property (
    acc_rd && paddr_in == REG_STAT_ADDR |-> prdata_out[18:16] == $past(pch)
      && prdata_out[STAT_FULL_BIT] == $past(stack_full_out))
    else $error("status read wrong");

  COV_ACK: cover property (int_ack_out);
  COV_FULL_REQ: cover property (stack_full_out && int_req_in);
  COV_PCL_WR: cover property (psel_in && penable_in && pwrite_in
                              && paddr_in == REG_PCL_ADDR);
endmodule // csa_core_properties

/* verification/csa_prog_mem.sv */
// program memory and interrupt request model for the core
`timescale 1ns/1ns
module csa_prog_mem
  import csa_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR = 11'h300
)(
  input  wire logic            clk_in,     // system clock
  input  wire logic            reset_n_in, // reset, active low
  input  wire logic [PC_W-1:0] addr_in,    // fetch address
  output logic      [15:0]     data_out,   // word at addr_in
  input  wire logic            raise_in,   // interrupt event
  input  wire logic            ack_in,     // acknowledge
  output logic                 req_out,    // pending request
  output logic      [PC_W-1:0] vector_out  // entry address
);
  logic [15:0] mem [0:2047];
  assign data_out   = mem[addr_in];
  assign vector_out = VECTOR;
  // flag held until acknowledged, also while the stack is full
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_out <= 1'b0;
    end else begin
      req_out <= raise_in || (req_out && !ack_in);
    end
  end
endmodule // csa_prog_mem

/* verification/test_cpu_sequencer_stack_alu.sv */
// self-checking testbench of the cpu sequencer core
`timescale 1ns/1ns
module test_cpu_sequencer_stack_alu
  import csa_pkg::*;
();
  logic            clk_in;
  logic            reset_n_in;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [PC_W-1:0] prog_addr;
  logic [15:0]     prog_data;
  logic            int_req;
  logic [PC_W-1:0] int_vector;
  logic            int_ack;
  logic [3:0]      phase;
  logic            stack_full;
  logic            raise;
  logic [31:0]     r;
  logic            e;
  int              c;
  int              acks;
  int              failures;
  int              tests_run;
  localparam logic [7:0] ALU_EXP [15] = '{8'h02, 8'h02, 8'hb6, 8'hb5,
    8'h04, 8'hfe, 8'hfa, 8'h59, 8'h53, 8'h53, 8'h4d, 8'h4c, 8'ha7, 8'ha5,
    8'h62};

  csa_core i_csa_core (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .prog_addr_out(prog_addr),
    .prog_data_in(prog_data), .int_req_in(int_req),
    .int_vector_in(int_vector), .int_ack_out(int_ack),
    .instruction_phase_clocks_out(phase), .stack_full_out(stack_full));
  csa_prog_mem i_csa_prog_mem (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(prog_addr),
    .data_out(prog_data), .raise_in(raise), .ack_in(int_ack),
    .req_out(int_req), .vector_out(int_vector));

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic put(input logic [PC_W-1:0] a, input logic [15:0] w);
    i_csa_prog_mem.mem[a] = w;
  endtask
  task automatic do_reset();
    reset_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // phase changes over n clocks, counted from one change
  task automatic count_ph(input int n, output int cnt);
    logic [3:0] last;
    int k;
    cnt = 0;
    k = 0;
    last = phase;
    while (phase === last && k < 4000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    last = phase;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (phase !== last) cnt++;
      last = phase;
    end
  endtask
  task automatic end_sim();
    $display("tests run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (int_ack === 1'b1) acks++;
  initial begin
    repeat (30000) @(posedge clk_in);
    failures++;
    end_sim();
  end
  initial begin
    {reset_n_in, psel, penable, pwrite, raise} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    acks = 0;
    for (int i = 0; i < 2048; i++) put(PC_W'(i), 16'hf000);
    do_reset();
    apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
    check(r, {31'h0, CTRL_OSC_RESET});
    apb(1'b0, 8'h0c, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    count_ph(8, c);
    check(32'(c), 32'h8);
    apb(1'b1, REG_CTRL_ADDR, 32'h1, r, e);
    apb(1'b0, REG_CTRL_ADDR, 32'h0, r, e);
    check(r, 32'h1);
    count_ph(SLOW_DIV, c);
    check(32'(c), 32'h1);
    apb(1'b1, REG_CTRL_ADDR, 32'h0, r, e);
    $display("register and phase test done");
    // operand in data byte 1, accumulator loaded, then one operation
    for (int op = 0; op < 15; op++) begin
      put(11'h000, 16'h20a6);
      put(11'h001, 16'h3001);
      put(11'h002, 16'h205c);
      put(11'h003, {4'h0, op[3:0], 8'h01});
      put(11'h004, 16'h4004);
      do_reset();
      repeat (80) @(posedge clk_in);
      apb(1'b0, REG_STAT_ADDR, 32'h0, r, e);
      check({24'h0, r[7:0]}, {24'h0, ALU_EXP[op]});
      if (op < 4) check({31'h0, r[STAT_CARRY_BIT]}, {31'h0, op < 2});
    end
    $display("alu test done");
    // decrement-skip, zero-skip, no skip on zero, then acc increment
    put(11'h000, 16'h2001);
    put(11'h001, 16'h3002);
    put(11'h002, 16'hb002);
    put(11'h003, 16'h2040);
    put(11'h004, 16'h8002);
    put(11'h005, 16'h2080);
    put(11'h006, 16'h9002);
    put(11'h007, 16'ha102);
    put(11'h008, 16'h4008);
    do_reset();
    repeat (80) @(posedge clk_in);
    apb(1'b0, REG_STAT_ADDR, 32'h0, r, e);
    check({24'h0, r[7:0]}, 32'h2);
    $display("skip test done");
    // ten nested calls, then a return started by a pc low byte write
    put(11'h000, 16'h5100);
    for (int i = 0; i < 9; i++) begin
      put(PC_W'(11'h100 + 16 * i), 16'h5000 | 16'(11'h110 + 16 * i));
      put(PC_W'(11'h101 + 16 * i), 16'h6000);
    end
    put(11'h101, 16'hf000);
    put(11'h102, 16'h4101);
    put(11'h190, 16'hf000);
    put(11'h191, 16'h4190);
    put(11'h192, 16'h6000);
    put(11'h300, 16'h7000);
    // nop loop at the return point leaves a slot for the interrupt
    put(11'h181, 16'hf000);
    put(11'h182, 16'h4181);
    do_reset();
    acks = 0;
    repeat (200) @(posedge clk_in);
    #1;
    check({31'h0, stack_full}, 32'h1);
    apb(1'b0, REG_STAT_ADDR, 32'h0, r, e);
    check({31'h0, r[STAT_FULL_BIT]}, 32'h1);
    check({29'h0, r[18:16]}, 32'h1);
    raise <= 1'b1;
    @(posedge clk_in);
    raise <= 1'b0;
    repeat (100) @(posedge clk_in);
    #1;
    check(32'(acks), 32'h0);
    apb(1'b1, REG_PCL_ADDR, 32'h92, r, e);
    repeat (300) @(posedge clk_in);
    #1;
    check(32'(acks), 32'h1);
    apb(1'b0, REG_PCL_ADDR, 32'h0, r, e);
    check({24'h0, r[7:0] & 8'hf8}, 32'h80);
    apb(1'b0, REG_STAT_ADDR, 32'h0, r, e);
    check({31'h0, r[STAT_FULL_BIT]}, 32'h0);
    check({29'h0, r[18:16]}, 32'h1);
    $display("stack and interrupt test done");
    end_sim();
  end
endmodule // test_cpu_sequencer_stack_alu

bind csa_core csa_core_properties i_csa_core_properties (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in),
  .int_req_in(int_req_in), .int_vector_in(int_vector_in),
  .int_ack_out(int_ack_out), .stack_full_out(stack_full_out),
  .instruction_phase_clocks_out(instruction_phase_clocks_out));
